// ---- include/scmc_pkg.sv ----
// Constants and types for the serial clock mode configuration block.
// Assumes a 32-bit Avalon-MM register bus and an 8-bit serial word.
package scmc_pkg;

   // Register byte offsets on the register bus.
   localparam logic [3:0] SCMC_CTRL_OFFSET = 4'h0;
   localparam logic [3:0] SCMC_DATA_OFFSET = 4'h4;
   localparam logic [3:0] SCMC_STAT_OFFSET = 4'h8;

   // Field positions of serial_module_control_one.
   localparam int SCMC_POL_BIT = 5;
   localparam int SCMC_EDGE_BIT = 4;
   localparam int SCMC_ORDER_BIT = 3;
   localparam int SCMC_SELEN_BIT = 2;
   localparam int SCMC_WCOL_BIT = 1;
   localparam int SCMC_DONE_BIT = 0;

   // Values after reset.
   localparam logic [7:0] SCMC_CTRL_RESET = 8'h00;
   localparam logic [7:0] SCMC_DATA_RESET = 8'h00;

   // Link clock cycles per half period of the serial clock.
   localparam logic [2:0] SCMC_HALF_CYCLES = 3'h4;
   // Index of the last bit of a serial word.
   localparam logic [2:0] SCMC_LAST_BIT = 3'h7;

   typedef enum logic [1:0] {
      LK_IDLE,
      LK_LEAD,
      LK_TRAIL
   } scmc_lk_state_t;

endpackage

// ---- hdl/scmc_top.sv ----
// SPI clock mode configuration register with an 8-bit master shifter behind it.
// Assumes an Avalon-MM master on CORE_CLK and a free-running LINK_CLK for the link.
//
// How it works
// - Control register bits 7 and 6 always read back as zero.
// - Polarity 0 keeps the idle serial clock high; polarity 1 keeps it low.
// - Idle-high clock: edge select 0 captures on rising, 1 on falling edge.
// - Idle-low clock with edge select 0 captures data on the rising edge.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module scmc_top
   import scmc_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic LINK_CLK,
   output logic SERIAL_CLOCK_LINE,
   output logic SERIAL_DATA_OUT,
   input wire logic SERIAL_DATA_IN,
   output logic SELECT_LINE_B,
   output logic SELECT_LINE_OE
);

   function automatic logic [7:0] bit_rev(input logic [7:0] d);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = d[7 - i];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus slave, one wait state per access.

   logic ack;
   logic clock_idle_polarity;
   logic capture_edge_select;
   logic bit_order_select;
   logic select_pin_enable;
   logic write_collision_flag;
   logic transfer_done_flag;
   logic [7:0] tx_data;
   logic [7:0] rx_data;
   logic busy;
   logic start_tgl;
   logic done_ev;
   logic wr_go;
   logic wr_ctrl;
   logic wr_data;
   logic [7:0] ctrl_view;

   assign AVS_WAITREQUEST = !ack;
   assign wr_go = ack && AVS_WRITE && AVS_BYTEENABLE[0];
   assign wr_ctrl = wr_go && (AVS_ADDRESS == SCMC_CTRL_OFFSET);
   assign wr_data = wr_go && (AVS_ADDRESS == SCMC_DATA_OFFSET);

   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[SCMC_POL_BIT] = clock_idle_polarity;
      ctrl_view[SCMC_EDGE_BIT] = capture_edge_select;
      ctrl_view[SCMC_ORDER_BIT] = bit_order_select;
      ctrl_view[SCMC_SELEN_BIT] = select_pin_enable;
      ctrl_view[SCMC_WCOL_BIT] = write_collision_flag;
      ctrl_view[SCMC_DONE_BIT] = transfer_done_flag;
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ack <= 1'b0;
      end else begin
         ack <= (AVS_READ || AVS_WRITE) && !ack;
      end
   end

   // Bits 7 and 6 are never stored, so they cannot read back as one.
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_READ && !ack) begin
         case (AVS_ADDRESS)
            SCMC_CTRL_OFFSET: AVS_READDATA <= {24'h00_0000, 2'h0, ctrl_view[5:0]};
            SCMC_DATA_OFFSET: AVS_READDATA <= {24'h00_0000, rx_data};
            SCMC_STAT_OFFSET: AVS_READDATA <= {31'h0000_0000, busy};
            default: AVS_READDATA <= 32'h0000_0000;
         endcase
      end
   end

   // The link latches polarity, edge and transmit order at the start of a word; select enable and receive order apply at once.
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         clock_idle_polarity <= SCMC_CTRL_RESET[SCMC_POL_BIT];
         capture_edge_select <= SCMC_CTRL_RESET[SCMC_EDGE_BIT];
         bit_order_select <= SCMC_CTRL_RESET[SCMC_ORDER_BIT];
         select_pin_enable <= SCMC_CTRL_RESET[SCMC_SELEN_BIT];
      end else if (wr_ctrl) begin
         clock_idle_polarity <= AVS_WRITEDATA[SCMC_POL_BIT];
         capture_edge_select <= AVS_WRITEDATA[SCMC_EDGE_BIT];
         bit_order_select <= AVS_WRITEDATA[SCMC_ORDER_BIT];
         select_pin_enable <= AVS_WRITEDATA[SCMC_SELEN_BIT];
      end
   end

   // Flags clear by writing zero; a setting event in the same cycle wins.
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         write_collision_flag <= SCMC_CTRL_RESET[SCMC_WCOL_BIT];
         transfer_done_flag <= SCMC_CTRL_RESET[SCMC_DONE_BIT];
      end else begin
         write_collision_flag <= (wr_data && busy) ||
            (write_collision_flag && !(wr_ctrl && !AVS_WRITEDATA[SCMC_WCOL_BIT]));
         transfer_done_flag <= done_ev ||
            (transfer_done_flag && !(wr_ctrl && !AVS_WRITEDATA[SCMC_DONE_BIT]));
      end
   end

   // A data write while busy is dropped so the word on the wire stays intact.
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         tx_data <= SCMC_DATA_RESET;
         start_tgl <= 1'b0;
         busy <= 1'b0;
      end else begin
         if (wr_data && !busy) begin
            tx_data <= AVS_WRITEDATA[7:0];
            start_tgl <= !start_tgl;
            busy <= 1'b1;
         end else if (done_ev) begin
            busy <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Crossings between the two clocks.

   logic dn_m;
   logic dn_s;
   logic dn_d;
   logic done_tgl;
   logic [7:0] lk_rx;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dn_m <= 1'b0;
         dn_s <= 1'b0;
         dn_d <= 1'b0;
      end else begin
         dn_m <= done_tgl;
         dn_s <= dn_m;
         dn_d <= dn_s;
      end
   end

   assign done_ev = dn_s ^ dn_d;

   // The link word is stable once the done toggle arrives.
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rx_data <= SCMC_DATA_RESET;
      end else if (done_ev) begin
         rx_data <= bit_order_select ? lk_rx : bit_rev(lk_rx);
      end
   end

   logic st_m;
   logic st_s;
   logic st_d;
   logic [3:0] cfg_m;
   logic [3:0] cfg_s;
   logic sdi_m;
   logic sdi_s;

   always_ff @(posedge LINK_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_m <= 1'b0;
         st_s <= 1'b0;
         st_d <= 1'b0;
         cfg_m <= 4'h0;
         cfg_s <= 4'h0;
         sdi_m <= 1'b0;
         sdi_s <= 1'b0;
      end else begin
         st_m <= start_tgl;
         st_s <= st_m;
         st_d <= st_s;
         cfg_m <= {select_pin_enable, bit_order_select, capture_edge_select,
                   clock_idle_polarity};
         cfg_s <= cfg_m;
         sdi_m <= SERIAL_DATA_IN;
         sdi_s <= sdi_m;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link side: serial clock generator and shifter.

   scmc_lk_state_t lk_state;
   logic lk_pol;
   logic lk_edge;
   logic [2:0] half_cnt;
   logic [2:0] bit_cnt;
   logic [7:0] shreg;
   logic start_ev;
   logic half_end;
   logic cap_first;
   logic sample;
   logic [7:0] tx_order;

   assign start_ev = st_s ^ st_d;
   // Busy holds tx_data still while a word is out, so it needs no synchroniser.
   assign tx_order = cfg_s[2] ? tx_data : bit_rev(tx_data);
   assign half_end = (half_cnt == SCMC_HALF_CYCLES - 3'h1);
   // The first edge leaves the idle level; it captures when it is the chosen edge.
   assign cap_first = lk_pol ^ lk_edge;
   assign sample = half_end && ((lk_state == LK_LEAD) ? cap_first :
                                (lk_state == LK_TRAIL) && !cap_first);

   always_ff @(posedge LINK_CLK or negedge RST_B) begin
      if (!RST_B) begin
         lk_state <= LK_IDLE;
         half_cnt <= 3'h0;
         bit_cnt <= 3'h0;
         done_tgl <= 1'b0;
      end else begin
         case (lk_state)
            LK_IDLE: begin
               half_cnt <= 3'h0;
               bit_cnt <= 3'h0;
               if (start_ev) begin
                  lk_state <= LK_LEAD;
               end
            end
            LK_LEAD: begin
               half_cnt <= half_end ? 3'h0 : half_cnt + 3'h1;
               if (half_end) begin
                  lk_state <= LK_TRAIL;
               end
            end
            LK_TRAIL: begin
               half_cnt <= half_end ? 3'h0 : half_cnt + 3'h1;
               if (half_end) begin
                  if (bit_cnt == SCMC_LAST_BIT) begin
                     lk_state <= LK_IDLE;
                     done_tgl <= !done_tgl;
                  end else begin
                     bit_cnt <= bit_cnt + 3'h1;
                     lk_state <= LK_LEAD;
                  end
               end
            end
            default: lk_state <= LK_IDLE;
         endcase
      end
   end

   // Mode is frozen per word so a late register write cannot make a stray edge.
   always_ff @(posedge LINK_CLK or negedge RST_B) begin
      if (!RST_B) begin
         lk_pol <= 1'b0;
         lk_edge <= 1'b0;
      end else if (lk_state == LK_IDLE) begin
         lk_pol <= cfg_s[0];
         lk_edge <= cfg_s[1];
      end
   end

   // Each edge falls on the last cycle of a half period.
   always_ff @(posedge LINK_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SERIAL_CLOCK_LINE <= 1'b1;
      end else if (lk_state == LK_IDLE) begin
         SERIAL_CLOCK_LINE <= !cfg_s[0];
      end else if (half_end) begin
         SERIAL_CLOCK_LINE <= (lk_state == LK_LEAD) ? lk_pol : !lk_pol;
      end
   end

   // Data launches on the edge that does not capture.
   always_ff @(posedge LINK_CLK or negedge RST_B) begin
      if (!RST_B) begin
         shreg <= 8'h00;
         lk_rx <= 8'h00;
         SERIAL_DATA_OUT <= 1'b0;
      end else begin
         if (lk_state == LK_IDLE && start_ev) begin
            if (cfg_s[0] ^ cfg_s[1]) begin
               SERIAL_DATA_OUT <= tx_order[7];
               shreg <= {tx_order[6:0], 1'b0};
            end else begin
               shreg <= tx_order;
            end
         end else if (half_end && lk_state != LK_IDLE && !sample) begin
            SERIAL_DATA_OUT <= shreg[7];
            shreg <= {shreg[6:0], 1'b0};
         end
         if (sample) begin
            lk_rx <= {lk_rx[6:0], sdi_s};
         end
      end
   end

   always_ff @(posedge LINK_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SELECT_LINE_B <= 1'b1;
         SELECT_LINE_OE <= 1'b0;
      end else begin
         SELECT_LINE_B <= (lk_state == LK_IDLE);
         SELECT_LINE_OE <= cfg_s[3];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence rise_s;
      !SERIAL_CLOCK_LINE ##1 SERIAL_CLOCK_LINE;
   endsequence

   sequence fall_s;
      SERIAL_CLOCK_LINE ##1 !SERIAL_CLOCK_LINE;
   endsequence

   ctrl_top_zero_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (AVS_READ && !ack && AVS_ADDRESS == SCMC_CTRL_OFFSET) |=> AVS_READDATA[7:6] == 2'h0)
      else $error("Control bits 7 and 6 read as one.");

   idle_clock_level_a: assert property (
      @(posedge LINK_CLK) disable iff (!RST_B)
      (lk_state == LK_IDLE && $past(lk_state) == LK_IDLE && $stable(cfg_s[0]))
      |-> SERIAL_CLOCK_LINE == !cfg_s[0])
      else $error("Idle serial clock at wrong level.");

   high_rise_cap_a: assert property (
      @(posedge LINK_CLK) disable iff (!RST_B)
      (sample && !lk_pol && !lk_edge) |-> rise_s)
      else $error("Idle-high edge 0 did not capture on rising edge.");

   high_fall_cap_a: assert property (
      @(posedge LINK_CLK) disable iff (!RST_B)
      (sample && !lk_pol && lk_edge) |-> fall_s)
      else $error("Idle-high edge 1 did not capture on falling edge.");

   low_rise_cap_a: assert property (
      @(posedge LINK_CLK) disable iff (!RST_B)
      (sample && lk_pol && !lk_edge) |-> rise_s)
      else $error("Idle-low edge 0 did not capture on rising edge.");

   low_fall_cap_a: assert property (
      @(posedge LINK_CLK) disable iff (!RST_B)
      (sample && lk_pol && lk_edge) |-> fall_s)
      else $error("Idle-low edge 1 did not capture on falling edge.");

   word_edge_count_a: assert property (
      @(posedge LINK_CLK) disable iff (!RST_B)
      (lk_state == LK_IDLE && start_ev) |-> ##65 (lk_state == LK_IDLE) ##1
      (SERIAL_CLOCK_LINE == !lk_pol))
      else $error("Word did not end at idle level after 16 half periods.");

endmodule

// ---- verif/scmc_peer.sv ----
// Behavioural SPI peer for the serial clock mode block.
// Assumes the bench states which serial clock edge captures data, MSB first.
`timescale 1ns/1ps
module scmc_peer (
   input wire logic link_clk,
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_b,
   input wire logic cap_rise,
   input wire logic [7:0] tx,
   output logic miso,
   output logic [7:0] rx
);
   int ncap = 0;
   initial miso = 1'b0;
   initial rx = 8'h00;
   ////////////////////////////////////////////////////////////
   // Outside a frame the line toggles, so a stale bit is never mistaken for data.
   // It moves on the falling link edge, so it never races the select edge.
   always @(negedge link_clk) begin
      if (sel_b) begin
         miso <= ~miso;
      end
   end
   always @(negedge sel_b) begin
      ncap = 0;
      miso <= tx[7];
   end
   // The next bit moves only on the edge after a capture.
   always @(sck) begin
      if (!sel_b && sck === cap_rise) begin
         rx = {rx[6:0], mosi};
         ncap = ncap + 1;
      end else if (!sel_b && ncap > 0 && ncap < 8) begin
         miso <= tx[7 - ncap];
      end
   end
endmodule

// ---- verif/scmc_top_test.sv ----
// Self-checking bench for the serial clock mode configuration block.
// Assumes scmc_pkg, the scmc_top design and the scmc_peer model.
`timescale 1ns/1ps
module scmc_top_test
   import scmc_pkg::*;
;
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] address = 4'h0;
   logic [3:0] be = 4'hF;
   logic read = 1'b0;
   logic write = 1'b0;
   logic cap_rise = 1'b1;
   logic [31:0] wdata = 32'h0;
   logic [31:0] readdata, got;
   logic waitreq, sck, mosi, miso, sel_b, sel_oe;
   logic [7:0] tx = 8'h00;
   logic [7:0] rx, cfg;
   logic [31:0] lfsr = 32'hA2EBB577;
   logic [31:0] expq[$];
   int miscompares = 0;
   int n_checks = 0;
   event rd_done;
   ////////////////////////////////////////////////////////////
   initial forever #50 core_clk = ~core_clk;
   initial begin
      #37;
      forever #40 link_clk = ~link_clk;
   end
   scmc_top scmc_top_inst (.CORE_CLK(core_clk), .RST_B(rst_b), .AVS_ADDRESS(address),
      .AVS_READ(read), .AVS_WRITE(write), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
      .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitreq), .LINK_CLK(link_clk),
      .SERIAL_CLOCK_LINE(sck), .SERIAL_DATA_OUT(mosi), .SERIAL_DATA_IN(miso),
      .SELECT_LINE_B(sel_b), .SELECT_LINE_OE(sel_oe));
   scmc_peer scmc_peer_inst (.link_clk(link_clk), .sck(sck), .mosi(mosi), .sel_b(sel_b),
      .cap_rise(cap_rise), .tx(tx), .miso(miso), .rx(rx));
   ////////////////////////////////////////////////////////////
   function automatic logic [7:0] rev8(input logic [7:0] d);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = d[7 - i];
      end
      return r;
   endfunction
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] act, input logic [31:0] exp);
      n_checks++;
      if (act !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, act, exp);
      end
   endtask
   always @(rd_done) begin
      check(got, expq.pop_front());
   end
   // Waitrequest is sampled 1 ns after each edge, so the race at the edge is avoided.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] en);
      logic ws;
      int k;
      k = 0;
      @(posedge core_clk);
      address <= a;
      wdata <= d;
      be <= en;
      read <= ~wr;
      write <= wr;
      do begin
         #1 ws = waitreq;
         @(posedge core_clk);
         k++;
      end while (ws !== 1'b0 && k < 50);
      got = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (k == 50) miscompares++;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, lfsr, 4'hF);
      -> rd_done;
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         bus(1'b0, SCMC_STAT_OFFSET, 32'h0, 4'hF);
         k++;
      end while (got[0] !== 1'b0 && k < 200);
      if (k == 200) miscompares++;
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      miscompares++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(SCMC_CTRL_OFFSET, {24'h0, SCMC_CTRL_RESET});
      check({31'h0, sck}, 32'h1);
      check({31'h0, sel_oe}, 32'h0);
      check({31'h0, sel_b}, 32'h1);
      bus(1'b1, SCMC_CTRL_OFFSET, 32'hFF, 4'hF);
      rd(SCMC_CTRL_OFFSET, 32'h3C);
      bus(1'b1, SCMC_CTRL_OFFSET, 32'h00, 4'h0);
      rd(SCMC_CTRL_OFFSET, 32'h3C);
      for (int i = 0; i < 4; i++) begin
         lfsr = next_rand(lfsr);
         bus(1'b1, SCMC_CTRL_OFFSET, lfsr, 4'hF);
         rd(SCMC_CTRL_OFFSET, {24'h0, 2'b00, lfsr[5:2], 2'b00});
      end
      rd(4'hC, 32'h0);
      $display("Register test done");
      // Every pairing of polarity and edge select, both bit orders, a collision in each word.
      for (int m = 0; m < 4; m++) begin
         cfg = {2'b00, m[1], m[0], ~m[1], 3'b100};
         cap_rise <= ~m[0];
         lfsr = next_rand(lfsr);
         tx <= lfsr[15:8];
         bus(1'b1, SCMC_CTRL_OFFSET, {24'h0, cfg}, 4'hF);
         repeat (4) @(posedge core_clk);
         check({31'h0, sck}, {31'h0, ~m[1]});
         check({31'h0, sel_oe}, 32'h1);
         bus(1'b1, SCMC_DATA_OFFSET, {24'h0, lfsr[7:0]}, 4'hF);
         bus(1'b1, SCMC_DATA_OFFSET, 32'h0, 4'hF);
         repeat (2) @(posedge core_clk);
         check({31'h0, sel_b}, 32'h0);
         wait_idle();
         check({24'h0, rx}, {24'h0, m[1] ? rev8(lfsr[7:0]) : lfsr[7:0]});
         check({31'h0, sck}, {31'h0, ~m[1]});
         check({31'h0, sel_b}, 32'h1);
         rd(SCMC_DATA_OFFSET, {24'h0, m[1] ? rev8(lfsr[15:8]) : lfsr[15:8]});
         rd(SCMC_CTRL_OFFSET, {24'h0, cfg | 8'h03});
         bus(1'b1, SCMC_CTRL_OFFSET, {24'h0, cfg}, 4'hF);
         rd(SCMC_CTRL_OFFSET, {24'h0, cfg});
         $display("Mode test %0d done", m);
      end
      conclude();
   end
endmodule
